// ===== hdl/pin_matrix_consts.svh
// Purpose: offsets, fields, reset values and counts of the pin matrix
// Assumes: byte addresses on a 32-bit apb bus
// Notes:   regions are selected by address bits 11:8
`ifndef PIN_MATRIX_CONSTS_SVH
`define PIN_MATRIX_CONSTS_SVH

`define PM_REGION_ROUTE_LO   4'h0
`define PM_REGION_ROUTE_HI   4'h2
`define PM_REGION_SYNC       4'h3
`define PM_REGION_PAD        4'h4
`define PM_REGION_OUTSEL     4'h5
`define PM_REGION_LEVEL      4'h6
`define PM_LEVEL_LOW_OFS     8'h00
`define PM_LEVEL_HIGH_OFS    8'h04

`define PM_ROUTE_SEL_LSB     0
`define PM_ROUTE_SEL_MSB     5
`define PM_ROUTE_INV_BIT     6
`define PM_ROUTE_EN_BIT      7
`define PM_ROUTE_RESET       8'h3c

`define PM_SYNC1_BIT         0
`define PM_SYNC2_BIT         1
`define PM_SYNC_RESET        2'h0

`define PM_PAD_IE_BIT        0
`define PM_PAD_WPU_BIT       1
`define PM_PAD_WPD_BIT       2
`define PM_PAD_FILT_BIT      3
`define PM_PAD_FUNC_LSB      4
`define PM_PAD_FUNC_MSB      6
`define PM_PAD_RESET         8'h10
`define PM_FUNC_MATRIX       3'h1

`define PM_OUTSEL_IDX_MSB    7
`define PM_OUTSEL_INV_BIT    8
`define PM_OUTSEL_RESET      9'h000

`define PM_CONST_ZERO_SEL    6'h3c
`define PM_CONST_ONE_SEL     6'h38
`define PM_FILTER_CYCLES     2'h3

`endif

// ===== hdl/pin_matrix_pkg.sv
// Purpose: shared types of the pin matrix
// Assumes: field positions from pin_matrix_consts.svh
// Notes:   types only
package pin_matrix_pkg;
    typedef logic [7:0] route_cfg_t;
    typedef logic [1:0] sync_cfg_t;
    typedef logic [7:0] pad_cfg_t;
    typedef logic [8:0] out_sel_t;
endpackage

// ===== hdl/pin_cond_if.sv
// Purpose: carries one pin's raw level, settings and clean level
// Assumes: single clock domain on the conditioner side
// Notes:   one instance per existing pin
interface pin_cond_if;
    logic raw;
    logic stage1_falling;
    logic stage2_falling;
    logic filter_en;
    logic input_en;
    logic level;
    modport cond (input raw, stage1_falling, stage2_falling, filter_en,
                  input_en, output level);
    modport top  (output raw, stage1_falling, stage2_falling, filter_en,
                  input_en, input level);
endinterface

// ===== hdl/pin_input_cond.sv
// Purpose: synchronises, filters and gates one pad input
// Assumes: i_ce freezes every flop, both edges alike
// Notes:   stage edges chosen per pin; third flop is always rising
`include "pin_matrix_consts.svh"
module pin_input_cond (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    input  wire logic i_ce,
    pin_cond_if.cond  p
);
    logic       s1_pos_reg;
    logic       s1_neg_reg;
    logic       s2_pos_reg;
    logic       s2_neg_reg;
    logic       s3_reg;
    logic       stage2_in;
    logic       stage2_out;
    logic       sync_reg;
    logic [1:0] cnt_reg;
    logic       filt_reg;
    logic       level_reg;

    // first stage on both edges, stage1_falling picks which one feeds the second stage
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            s1_pos_reg <= 1'b0;
        else if (i_ce)
            s1_pos_reg <= p.raw;

    always_ff @(negedge i_mclk or posedge i_reset)
        if (i_reset)
            s1_neg_reg <= 1'b0;
        else if (i_ce)
            s1_neg_reg <= p.raw;

    assign stage2_in = p.stage1_falling ? s1_neg_reg : s1_pos_reg;

    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            s2_pos_reg <= 1'b0;
        else if (i_ce)
            s2_pos_reg <= stage2_in;

    always_ff @(negedge i_mclk or posedge i_reset)
        if (i_reset)
            s2_neg_reg <= 1'b0;
        else if (i_ce)
            s2_neg_reg <= stage2_in;

    assign stage2_out = p.stage2_falling ? s2_neg_reg : s2_pos_reg;

    // change accepted only once stages two and three agree
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
        begin
            s3_reg   <= 1'b0;
            sync_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            s3_reg <= stage2_out;
            if (s3_reg == stage2_out)
                sync_reg <= s3_reg;
        end

    // a level must hold three cycles before it passes
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
        begin
            cnt_reg  <= 2'h0;
            filt_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            if (sync_reg == filt_reg)
                cnt_reg <= 2'h0;
            else if (cnt_reg == `PM_FILTER_CYCLES - 2'h1)
            begin
                filt_reg <= sync_reg;
                cnt_reg  <= 2'h0;
            end
            else
                cnt_reg <= cnt_reg + 2'h1;
        end

    // closed input gate reads low
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            level_reg <= 1'b0;
        else if (i_ce)
            level_reg <= p.input_en &
                         (p.filter_en ? filt_reg : sync_reg);

    assign p.level = level_reg;
endmodule

// ===== hdl/pin_matrix.sv
// Purpose: pin to peripheral input matrix with pad and output control
// Assumes: apb slave with one wait state, single clock i_mclk
// Notes:   pin slots 22 to 25 do not exist and read as zero
//
// Added by the designer: the APB interface to the registers and the address map.
`include "pin_matrix_consts.svh"
module pin_matrix #(
    parameter int PIN_SLOTS = 49,
    parameter int NUM_IN    = 175,
    parameter int NUM_OUT   = 184
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_reset,
    input  wire logic                 i_ce,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [PIN_SLOTS-1:0] i_pad_in,
    output logic      [PIN_SLOTS-1:0] o_pad_out,
    output logic      [PIN_SLOTS-1:0] o_pad_oe,
    output logic      [PIN_SLOTS-1:0] o_pad_input_gate,
    output logic      [PIN_SLOTS-1:0] o_pad_weak_pull_high,
    output logic      [PIN_SLOTS-1:0] o_pad_weak_pull_low,
    input  wire logic [NUM_IN-1:0]    i_direct_in,
    output logic      [NUM_IN-1:0]    o_periph_in,
    input  wire logic [NUM_OUT-1:0]   i_periph_out,
    input  wire logic [NUM_OUT-1:0]   i_periph_oe
);
    pin_matrix_pkg::route_cfg_t peripheral_input_route_cfg_reg [NUM_IN];
    pin_matrix_pkg::sync_cfg_t  per_pin_sync_config_reg [PIN_SLOTS];
    pin_matrix_pkg::pad_cfg_t   per_pin_pad_config_reg [PIN_SLOTS];
    pin_matrix_pkg::out_sel_t   out_sel_reg [PIN_SLOTS];

    logic [PIN_SLOTS-1:0] pin_level;
    logic [63:0]          level_bits;
    logic                 access;
    logic                 commit;
    logic [3:0]           region;
    logic [7:0]           word_idx;
    logic                 mapped;
    logic [31:0]          rdata_next;

    // pins 22..25 are absent from the package
    function automatic logic pin_exists(input int x);
        return (x < 22) || (x > 25 && x < 49);
    endfunction

    // inputs wired to a direct pad path; all others are matrix only
    function automatic logic can_bypass(input int y);
        return (y <= 3) || (y >= 7 && y <= 13) || (y == 15) || (y == 16)
            || (y >= 101 && y <= 110) || (y >= 120 && y <= 123)
            || (y >= 155 && y <= 159);
    endfunction

    // one wait state so read data and pready leave flops
    assign access   = i_psel & i_penable;
    assign commit   = access & o_pready;
    assign region   = i_paddr[11:8];
    assign word_idx = i_paddr[9:2];

    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            o_pready <= 1'b0;
        else if (i_ce)
            o_pready <= access & ~o_pready;

    always_comb
    begin
        mapped     = 1'b0;
        rdata_next = 32'h0000_0000;
        if (region <= `PM_REGION_ROUTE_HI)
        begin
            if (32'(word_idx) < NUM_IN)
            begin
                mapped     = 1'b1;
                rdata_next = {24'h000000,
                              peripheral_input_route_cfg_reg[word_idx]};
            end
        end
        else if (region == `PM_REGION_SYNC || region == `PM_REGION_PAD
                 || region == `PM_REGION_OUTSEL)
        begin
            if (i_paddr[7:2] < 6'(PIN_SLOTS))
            begin
                mapped = 1'b1;
                if (pin_exists(int'(i_paddr[7:2])))
                begin
                    case (region)
                        `PM_REGION_SYNC:
                            rdata_next = {30'h0,
                                per_pin_sync_config_reg[i_paddr[7:2]]};
                        `PM_REGION_PAD:
                            rdata_next = {24'h000000,
                                per_pin_pad_config_reg[i_paddr[7:2]]};
                        default:
                            rdata_next = {23'h000000,
                                out_sel_reg[i_paddr[7:2]]};
                    endcase
                end
            end
        end
        else if (region == `PM_REGION_LEVEL)
        begin
            if (i_paddr[7:0] == `PM_LEVEL_LOW_OFS)
            begin
                mapped     = 1'b1;
                rdata_next = level_bits[31:0];
            end
            else if (i_paddr[7:0] == `PM_LEVEL_HIGH_OFS)
            begin
                mapped     = 1'b1;
                rdata_next = level_bits[63:32];
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
        begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_ce && access && !o_pready)
        begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata_next;
            o_pslverr <= ~mapped;
        end

    assign level_bits = {{(64 - PIN_SLOTS){1'b0}}, pin_level};

    // route configuration, one word per peripheral input
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
        begin
            for (int y = 0; y < NUM_IN; y++)
                peripheral_input_route_cfg_reg[y] <= `PM_ROUTE_RESET;
        end
        else if (i_ce && commit && i_pwrite && mapped
                 && region <= `PM_REGION_ROUTE_HI)
            peripheral_input_route_cfg_reg[word_idx] <= i_pwdata[7:0];

    // per pin sync, pad and output select words
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
        begin
            for (int x = 0; x < PIN_SLOTS; x++)
            begin
                per_pin_sync_config_reg[x] <= `PM_SYNC_RESET;
                per_pin_pad_config_reg[x]  <= `PM_PAD_RESET;
                out_sel_reg[x]             <= `PM_OUTSEL_RESET;
            end
        end
        else if (i_ce && commit && i_pwrite && mapped
                 && pin_exists(int'(i_paddr[7:2])))
        begin
            case (region)
                `PM_REGION_SYNC:
                    per_pin_sync_config_reg[i_paddr[7:2]] <= i_pwdata[1:0];
                `PM_REGION_PAD:
                    per_pin_pad_config_reg[i_paddr[7:2]] <= i_pwdata[7:0];
                `PM_REGION_OUTSEL:
                    out_sel_reg[i_paddr[7:2]] <= i_pwdata[8:0];
                default:
                    ;
            endcase
        end

    // per pin conditioning and pad drive
    generate
        for (genvar x = 0; x < PIN_SLOTS; x++)
        begin : g_pin
            if ((x < 22) || (x > 25))
            begin : g_real
                pin_cond_if cif ();
                logic [7:0] osel;
                logic       oinv;
                logic       to_matrix;

                assign cif.raw            = i_pad_in[x];
                assign cif.stage1_falling =
                    per_pin_sync_config_reg[x][`PM_SYNC1_BIT];
                assign cif.stage2_falling =
                    per_pin_sync_config_reg[x][`PM_SYNC2_BIT];
                assign cif.filter_en =
                    per_pin_pad_config_reg[x][`PM_PAD_FILT_BIT];
                assign cif.input_en =
                    per_pin_pad_config_reg[x][`PM_PAD_IE_BIT];
                assign pin_level[x] = cif.level;

                pin_input_cond u_cond (
                    .i_mclk  (i_mclk),
                    .i_reset (i_reset),
                    .i_ce    (i_ce),
                    .p       (cif)
                );

                assign osel = out_sel_reg[x][`PM_OUTSEL_IDX_MSB:0];
                assign oinv = out_sel_reg[x][`PM_OUTSEL_INV_BIT];
                assign to_matrix =
                    per_pin_pad_config_reg[x][`PM_PAD_FUNC_MSB:`PM_PAD_FUNC_LSB]
                    == `PM_FUNC_MATRIX;

                always_ff @(posedge i_mclk or posedge i_reset)
                    if (i_reset)
                    begin
                        o_pad_out[x]            <= 1'b0;
                        o_pad_oe[x]             <= 1'b0;
                        o_pad_input_gate[x]     <= 1'b0;
                        o_pad_weak_pull_high[x] <= 1'b0;
                        o_pad_weak_pull_low[x]  <= 1'b0;
                    end
                    else if (i_ce)
                    begin
                        // direct outputs are wired outside, so drive off
                        if (to_matrix && 32'(osel) < NUM_OUT)
                        begin
                            o_pad_out[x] <= i_periph_out[osel] ^ oinv;
                            o_pad_oe[x]  <= i_periph_oe[osel];
                        end
                        else
                        begin
                            o_pad_out[x] <= 1'b0;
                            o_pad_oe[x]  <= 1'b0;
                        end
                        o_pad_input_gate[x] <=
                            per_pin_pad_config_reg[x][`PM_PAD_IE_BIT];
                        o_pad_weak_pull_high[x] <=
                            per_pin_pad_config_reg[x][`PM_PAD_WPU_BIT];
                        o_pad_weak_pull_low[x] <=
                            per_pin_pad_config_reg[x][`PM_PAD_WPD_BIT];
                    end
            end
            else
            begin : g_absent
                assign pin_level[x] = 1'b0;
                always_ff @(posedge i_mclk or posedge i_reset)
                    if (i_reset)
                    begin
                        o_pad_out[x]            <= 1'b0;
                        o_pad_oe[x]             <= 1'b0;
                        o_pad_input_gate[x]     <= 1'b0;
                        o_pad_weak_pull_high[x] <= 1'b0;
                        o_pad_weak_pull_low[x]  <= 1'b0;
                    end
            end
        end
    endgenerate

    // crossbar: each peripheral input reads any pin, many may share one
    generate
        for (genvar y = 0; y < NUM_IN; y++)
        begin : g_route
            logic [5:0] sel;
            logic       inv;
            logic       use_matrix;
            logic       src;

            assign sel = peripheral_input_route_cfg_reg[y]
                         [`PM_ROUTE_SEL_MSB:`PM_ROUTE_SEL_LSB];
            assign inv = peripheral_input_route_cfg_reg[y][`PM_ROUTE_INV_BIT];
            assign use_matrix = !can_bypass(y)
                || peripheral_input_route_cfg_reg[y][`PM_ROUTE_EN_BIT];

            always_comb
            begin
                if (sel == `PM_CONST_ZERO_SEL)
                    src = 1'b0;
                else if (sel == `PM_CONST_ONE_SEL)
                    src = 1'b1;
                else if (32'(sel) < PIN_SLOTS)
                    src = pin_level[sel];
                else
                    src = 1'b0;
            end

            // direct value still leaves a flop; no sync chain on it
            always_ff @(posedge i_mclk or posedge i_reset)
                if (i_reset)
                    o_periph_in[y] <= 1'b0;
                else if (i_ce)
                    o_periph_in[y] <= use_matrix ? (src ^ inv)
                                                 : i_direct_in[y];
        end
    endgenerate
endmodule

// ===== sim/pin_matrix_props.sv
// Purpose: concurrent checks on the pin matrix top ports
// Assumes: apb answer after one wait state; input 4 route at 0x010
// Notes:   shadows route 4 by snooping committed apb writes
module pin_matrix_props #(
    parameter int PIN_SLOTS = 49,
    parameter int NUM_IN    = 175,
    parameter int NUM_OUT   = 184
) (
    input wire logic                 i_mclk,
    input wire logic                 i_reset,
    input wire logic                 i_ce,
    input wire logic                 i_psel,
    input wire logic                 i_penable,
    input wire logic                 i_pwrite,
    input wire logic [11:0]          i_paddr,
    input wire logic [31:0]          i_pwdata,
    input wire logic [31:0]          o_prdata,
    input wire logic                 o_pready,
    input wire logic                 o_pslverr,
    input wire logic [PIN_SLOTS-1:0] o_pad_input_gate,
    input wire logic [PIN_SLOTS-1:0] o_pad_weak_pull_high,
    input wire logic [PIN_SLOTS-1:0] o_pad_weak_pull_low,
    input wire logic [NUM_IN-1:0]    o_periph_in
);
    logic [7:0] route4_reg;
    logic       commit;
    assign commit = o_pready && i_psel && i_penable && i_pwrite;
    // input 4 has no direct path, so only select and invert matter
    always_ff @(posedge i_mclk or posedge i_reset)
        if (i_reset)
            route4_reg <= 8'h3c;
        else if (i_ce && commit && i_paddr == 12'h010)
            route4_reg <= i_pwdata[7:0];
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_wait;
        i_psel && i_penable && !o_pready && i_ce;
    endsequence
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence
    answer_time_a: assert property (s_wait |=> s_answer)
        else $error("apb answer late or too long");
    ready_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("pready outside an access");
    unmapped_err_a: assert property ((s_wait and i_paddr[11:8] > 4'h6)
        |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    write_rdata_a: assert property (commit |-> o_prdata == 32'h0)
        else $error("read data not zero on write");
    level_high_a: assert property (
        o_pready && !i_pwrite && i_paddr == 12'h604
        |-> o_prdata[31:17] == 15'h0)
        else $error("level bank shows absent pins");
    absent_slots_a: assert property (
        {o_pad_input_gate[25:22], o_pad_weak_pull_high[25:22],
         o_pad_weak_pull_low[25:22]} == 12'h0)
        else $error("absent pad slot driven");
    pad_change_a: assert property (
        $changed({o_pad_input_gate, o_pad_weak_pull_high,
                  o_pad_weak_pull_low})
        |-> $past(commit) || $past(commit, 2))
        else $error("pad control moved without a write");
    const_zero_a: assert property (
        $stable(route4_reg) && route4_reg[5:0] == 6'h3c
        |-> o_periph_in[4] == route4_reg[6])
        else $error("constant zero code wrong");
    const_one_a: assert property (
        $stable(route4_reg) && route4_reg[5:0] == 6'h38
        |-> o_periph_in[4] == !route4_reg[6])
        else $error("constant one code wrong");
    bad_sel_a: assert property (
        $stable(route4_reg) && route4_reg[5:0] > 6'h30
        && route4_reg[5:0] != 6'h38 && route4_reg[5:0] != 6'h3c
        |-> o_periph_in[4] == route4_reg[6])
        else $error("select of no pin not zero");
endmodule

bind pin_matrix pin_matrix_props #(
    .PIN_SLOTS(PIN_SLOTS),
    .NUM_IN   (NUM_IN),
    .NUM_OUT  (NUM_OUT)
) u_props (
    .i_mclk, .i_reset, .i_ce, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .o_pad_input_gate, .o_pad_weak_pull_high, .o_pad_weak_pull_low,
    .o_periph_in
);

// ===== sim/periph_model.sv
// Purpose: stands in for the peripherals around the pin matrix
// Assumes: outputs move only right after a rising edge
// Notes:   out and oe frozen when not running, out shifting and oe flipping when running
module periph_model (
    input  wire logic         i_mclk,
    input  wire logic         i_run,
    input  wire logic [174:0] i_periph_in,
    output logic      [183:0] o_periph_out,
    output logic      [183:0] o_periph_oe,
    output logic      [174:0] o_seen
);
    initial
    begin
        o_periph_out = 184'h5;
        o_periph_oe  = '1;
        o_seen       = '0;
    end
    // every oe bit flips each running cycle, so a stale route cannot pass unseen
    always @(posedge i_mclk)
    begin
        o_seen <= i_periph_in;
        if (i_run)
        begin
            o_periph_out <= {o_periph_out[182:0], ~o_periph_out[183]};
            o_periph_oe  <= ~o_periph_oe;
        end
    end
endmodule

// ===== sim/pin_matrix_tb.sv
// Purpose: register-level tests of the pin matrix
// Assumes: apb answer waited for, never counted in advance
// Notes:   clock enable held high throughout
module pin_matrix_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic         mclk      = 1'h0;
    logic         reset     = 1'h1;
    logic         psel      = 1'h0;
    logic         penable   = 1'h0;
    logic         pwrite    = 1'h0;
    logic         run       = 1'h0;
    logic [11:0]  paddr     = 12'h0;
    logic [31:0]  pwdata    = 32'h0;
    logic [48:0]  pad_in    = 49'h100_0040_0008;
    logic [174:0] direct_in = 175'h0;
    logic [31:0]  prdata, q;
    logic         pready, pslverr, last_err, hit;
    logic [48:0]  pad_out, pad_oe, gate, wph, wpl;
    logic [174:0] periph_in, seen;
    logic [183:0] periph_out, periph_oe;
    logic [1:0]   p;
    logic [7:0]   cfg [6] = '{8'h3c, 8'h7c, 8'h38, 8'h78, 8'h96, 8'h3f};
    logic [5:0]   cexp      = 6'h06;
    int           err_total = 0;
    int           num_checks = 0;
    int           cycles    = 0;

    always #5 mclk = ~mclk;

    pin_matrix i_dut (
        .i_mclk(mclk), .i_reset(reset), .i_ce(1'h1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pad_in(pad_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .o_pad_input_gate(gate),
        .o_pad_weak_pull_high(wph), .o_pad_weak_pull_low(wpl),
        .i_direct_in(direct_in), .o_periph_in(periph_in),
        .i_periph_out(periph_out), .i_periph_oe(periph_oe)
    );
    periph_model i_periph (
        .i_mclk(mclk), .i_run(run), .i_periph_in(periph_in),
        .o_periph_out(periph_out), .o_periph_oe(periph_oe), .o_seen(seen)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] v,
                       input logic [31:0] e);
        num_checks++;
        if (v !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // request held until pready is sampled high, released after it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
            @(posedge mclk);
        while (pready !== 1'h1);
        q = prdata;
        last_err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string s);
        apb(1'h0, a, 32'h0);
        chk(s, q, e);
    endtask
    task automatic pulse(input int n, input logic e);
        hit = 1'h0;
        pad_in[40] <= 1'h1;
        tick(n);
        pad_in[40] <= 1'h0;
        repeat (14)
        begin
            @(posedge mclk);
            hit = hit | periph_in[4];
        end
        chk("filter", 32'(hit), 32'(e));
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        tick(2);
        reset <= 1'h0;
        rd(12'h010, 32'h3c, "route reset");
        rd(12'h2b8, 32'h3c, "route 174");
        rd(12'h300, 32'h0, "sync reset");
        rd(12'h4c0, 32'h10, "pad reset");
        rd(12'h500, 32'h0, "outsel reset");
        wr(12'h458, 32'h7);
        rd(12'h458, 32'h0, "absent pad");
        rd(12'h7f0, 32'h0, "unmapped");
        chk("slverr", 32'(last_err), 32'h1);
        rd(12'h600, 32'h0, "level ie off");
        wr(12'h40c, 32'h17);
        wr(12'h4a0, 32'h11);
        tick(10);
        rd(12'h600, 32'h8, "level low");
        rd(12'h604, 32'h100, "level high");
        chk("pad ctl", 32'({gate[3], wph[3], wpl[3]}), 32'h7);
        wr(12'h40c, 32'h13);
        tick(2);
        chk("pulls", 32'({wph[3], wpl[3]}), 32'h2);
        $display("test pads done");
        wr(12'h010, 32'ha8);
        wr(12'h144, 32'he8);
        tick(3);
        chk("route 4", 32'(periph_in[4]), 32'h1);
        chk("invert 81", 32'(seen[81]), 32'h0);
        pad_in[40] <= 1'h0;
        tick(10);
        chk("route 4 low", 32'(periph_in[4]), 32'h0);
        chk("invert 81 low", 32'(seen[81]), 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            wr(12'h010, 32'(cfg[i]));
            tick(3);
            chk("constant", 32'(periph_in[4]), 32'(cexp[i]));
        end
        $display("test routes done");
        direct_in[0]   <= 1'h1;
        direct_in[101] <= 1'h1;
        direct_in[100] <= 1'h1;
        tick(2);
        chk("direct 0", 32'(periph_in[0]), 32'h1);
        chk("direct 101", 32'(periph_in[101]), 32'h1);
        chk("no direct 100", 32'(periph_in[100]), 32'h0);
        wr(12'h010, 32'h28);
        pad_in[40] <= 1'h1;
        tick(10);
        chk("matrix only", 32'(periph_in[4]), 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            wr(12'h3a0, 32'(k));
            pad_in[40] <= ~pad_in[40];
            tick(8);
            chk("sync edge", 32'(periph_in[4]), 32'(pad_in[40]));
        end
        rd(12'h3a0, 32'h3, "sync cfg");
        wr(12'h4a0, 32'h19);
        pad_in[40] <= 1'h0;
        tick(16);
        pulse(2, 1'h0);
        pulse(3, 1'h1);
        $display("test inputs done");
        wr(12'h514, 32'h10a);
        tick(3);
        chk("pad drive", 32'({pad_oe[5], pad_out[5]}), 32'h3);
        run <= 1'h1;
        @(posedge mclk);
        p = {periph_oe[10], ~periph_out[10]};
        repeat (6)
        begin
            @(posedge mclk);
            chk("pad follow", 32'({pad_oe[5], pad_out[5]}), 32'(p));
            p = {periph_oe[10], ~periph_out[10]};
        end
        wr(12'h414, 32'h21);
        tick(3);
        chk("no matrix", 32'(pad_oe[5]), 32'h0);
        $display("test outputs done");
        complete_run();
    end
endmodule
